// [dv/cev_checker.sv]
// Port assertions for the vectoring block
`timescale 1ns/10ps
module cev_checker
    import cev_pkg::*;
(
    input wire logic I_CLOCK, // Clock
    input wire logic I_NRST, // Reset
    input wire logic [7:0] I_VEC_NUM, // Vector
    input wire logic I_BASE_WE, // Base write
    input wire logic I_BASE_PRIV, // Privileged
    input wire logic [2:0] I_UNCORR_ERR, // Uncorrectable
    input wire logic I_SW_RESET, // Soft reset
    input wire logic O_SLOT_VALID, // Slot valid
    input wire logic [31:0] O_SLOT_ADDR, // Slot address
    input wire logic [31:0] O_BASE, // Base
    input wire logic O_BASE_REJECT, // Refused
    input wire logic O_BUS_FAULT, // Fault
    input wire logic [1:0] O_WD_RESET_REQ, // Requests
    input wire logic O_NMI_WD_RESET_REQ, // NMI request
    input wire logic O_NONMASKABLE_EVENT // NMI event
);
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (!I_NRST);
    sequence bad_wr; I_BASE_WE && !I_BASE_PRIV; endsequence
    chk_slot_addr: assert property (
        O_SLOT_VALID |-> O_SLOT_ADDR == $past(O_BASE) + 4 * $past(I_VEC_NUM))
        else $error("slot address wrong");
    chk_bad_write: assert property (bad_wr |=> O_BASE_REJECT && $stable(O_BASE))
        else $error("unprivileged write not refused");
    chk_base_priv: assert property (
        $changed(O_BASE) |-> $past(I_BASE_WE) && $past(I_BASE_PRIV))
        else $error("base moved without privileged write");
    chk_base_range: assert property ($changed(O_BASE) |->
        O_BASE >= BASE_MIN && O_BASE <= BASE_MAX && (O_BASE & BASE_ALIGN_MASK) == 0)
        else $error("base out of range");
    chk_reject_cause: assert property (O_BASE_REJECT |-> $past(I_BASE_WE))
        else $error("refusal without write");
    chk_bus_fault: assert property (|I_UNCORR_ERR |=> O_BUS_FAULT)
        else $error("uncorrectable error gave no fault");
    chk_wd_req: assert property ($rose(I_SW_RESET) |=> &O_WD_RESET_REQ)
        else $error("watchdog requests missing");
    chk_nmi_wd: assert property ($rose(O_NONMASKABLE_EVENT) |=> O_NMI_WD_RESET_REQ)
        else $error("nmi watchdog request missing");
endmodule // cev_checker

bind cev_vectoring cev_checker cev_checker_inst (.*);

// [dv/cev_core_model.sv]
// Core-side model that asks for vector slots
`timescale 1ns/10ps
module cev_core_model (
    input wire logic i_clock, // Clock
    input wire logic i_valid, // Slot valid
    output logic o_req = 1'b0, // Lookup pulse
    output logic [7:0] o_num = 8'h00 // Vector number
);
    // Number inverted when idle so a stale value is never taken
    task automatic fetch(input logic [7:0] n, output logic v);
        @(posedge i_clock);
        #1;
        o_req = 1'b1;
        o_num = n;
        @(posedge i_clock);
        #1;
        o_req = 1'b0;
        o_num = ~n;
        v = i_valid;
    endtask
endmodule // cev_core_model

// [dv/cev_vectoring_tb.sv]
// Self-checking bench for the vectoring block
`timescale 1ns/10ps
module cev_vectoring_tb;
    import cev_pkg::*;
    logic I_CLOCK = 1'b0;
    logic I_NRST = 1'b0;
    logic I_VEC_REQ, I_BASE_WE, I_BASE_PRIV, I_PRIO_WE, I_CLK_FAIL, I_EXPANDER_ERR, I_NMI_PIN;
    logic I_NMI_WD_TIMEOUT, I_MEM_ACCESS_ERR, I_SW_RESET, O_SP_FETCH, O_SLOT_VALID, O_SLOT_FIXED;
    logic O_BASE_REJECT, O_NMI, O_BUS_FAULT, O_BUS_FAULT_IMPRECISE, O_NMI_WD_RESET_REQ;
    logic O_NONMASKABLE_EVENT, v;
    logic [7:0] I_VEC_NUM, I_PRIO_NUM;
    logic [31:0] I_BASE_WDATA, O_SLOT_ADDR, O_BASE;
    logic [2:0] I_PRIO_WDATA, I_UNCORR_ERR, O_SLOT_PRIO;
    logic [1:0] I_SINGLE_ERR, O_SINGLE_IRQ, O_WD_RESET_REQ;
    int errors = 0;
    int checks = 0;
    int cyc = 0;
    always #5 I_CLOCK = ~I_CLOCK;
    cev_vectoring cev_vectoring_inst (.*);
    cev_core_model cev_core_model_inst (.i_clock(I_CLOCK), .i_valid(O_SLOT_VALID),
        .o_req(I_VEC_REQ), .o_num(I_VEC_NUM));
    task automatic chk(input string nm, input logic [39:0] got, exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic results;
        $display("Checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge I_CLOCK) begin
        cyc++;
        if (cyc == 2000) begin
            errors++;
            results();
        end
    end
    task automatic t_vec(input logic [31:0] b);
        logic [7:0] n [5] = '{8'h02, 8'h04, 8'h05, 8'h10, 8'h6b};
        for (int k = 0; k < 5; k++) begin
            cev_core_model_inst.fetch(n[k], v);
            chk("slot", {v, O_SLOT_ADDR}, {1'b1, b + 4 * n[k]});
            chk("prio", {O_SLOT_FIXED, O_SLOT_PRIO},
                {n[k] == VEC_NMI, n[k] == VEC_NMI ? 3'h6 : 3'h0});
        end
        $display("Test vectors done");
    endtask
    task automatic t_base;
        logic [32:0] w [6] = '{{1'b0, 32'h400}, {1'b1, 32'h100}, {1'b1, 32'h4000_0000},
            {1'b1, 32'h410}, {1'b1, 32'h200}, {1'b1, BASE_MAX}};
        for (int k = 0; k < 6; k++) begin
            @(posedge I_CLOCK);
            #1;
            {I_BASE_WE, I_BASE_PRIV, I_BASE_WDATA} = {1'b1, w[k]};
            @(posedge I_CLOCK);
            #1;
            {I_BASE_WE, I_BASE_WDATA} = {1'b0, ~w[k][31:0]};
            chk("reject", O_BASE_REJECT, k < 4);
            chk("base", O_BASE, k < 4 ? RESET_BASE : w[k][31:0]);
        end
        $display("Test base done");
    endtask
    task automatic t_evt;
        for (int k = 0; k < 4; k++) begin
            {I_CLK_FAIL, I_EXPANDER_ERR, I_NMI_PIN, I_NMI_WD_TIMEOUT} = 4'h1 << k;
            repeat (6) @(posedge I_CLOCK);
            #1;
            chk("nmi", {O_NMI, O_NONMASKABLE_EVENT, O_NMI_WD_RESET_REQ}, 3'h7);
            {I_CLK_FAIL, I_EXPANDER_ERR, I_NMI_PIN, I_NMI_WD_TIMEOUT} = 4'h0;
            repeat (6) @(posedge I_CLOCK);
            #1;
            chk("nmi off", O_NMI, 1'b0);
        end
        {I_SINGLE_ERR, I_UNCORR_ERR, I_SW_RESET} = 6'h29;
        @(posedge I_CLOCK);
        #1;
        chk("errs", {O_SINGLE_IRQ, O_BUS_FAULT, O_BUS_FAULT_IMPRECISE, O_WD_RESET_REQ},
            6'h2f);
        {I_SINGLE_ERR, I_UNCORR_ERR, I_MEM_ACCESS_ERR} = 6'h01;
        @(posedge I_CLOCK);
        #1;
        chk("precise", {O_SINGLE_IRQ, O_BUS_FAULT, O_BUS_FAULT_IMPRECISE},
            4'h2);
        $display("Test events done");
    endtask
    task automatic t_reset;
        I_NRST = 1'b0;
        repeat (12) @(posedge I_CLOCK);
        #1;
        I_NRST = 1'b1;
        chk("base", O_BASE, RESET_BASE);
        repeat (2) @(posedge I_CLOCK);
        #1;
        chk("sp fetch", {O_SP_FETCH, O_SLOT_ADDR}, {1'b1, RESET_BASE});
        $display("Test reset done");
    endtask
    task automatic t_prio;
        // Writes: vector and level; fixed vectors must ignore theirs
        logic [10:0] w [4] = '{{8'h10, 3'h5}, {8'h05, 3'h3}, {8'h02, 3'h1}, {8'h03, 3'h7}};
        // Lookups: vector, fixed flag and level expected
        logic [11:0] e [5] = '{{8'h10, 4'h5}, {8'h05, 4'h3}, {8'h02, 4'he}, {8'h03, 4'h8},
            {8'h6c, 4'h0}};
        for (int k = 0; k < 4; k++) begin
            @(posedge I_CLOCK);
            #1;
            {I_PRIO_WE, I_PRIO_NUM, I_PRIO_WDATA} = {1'b1, w[k]};
            @(posedge I_CLOCK);
            #1;
            I_PRIO_WE = 1'b0;
        end
        for (int k = 0; k < 5; k++) begin
            cev_core_model_inst.fetch(e[k][11:4], v);
            chk("prio wr", {v, O_SLOT_FIXED, O_SLOT_PRIO}, {1'b1, e[k][3:0]});
        end
        $display("Test priority done");
    endtask
    initial begin
        {I_BASE_WE, I_BASE_PRIV, I_BASE_WDATA, I_PRIO_WE, I_PRIO_NUM, I_PRIO_WDATA} = '0;
        {I_CLK_FAIL, I_EXPANDER_ERR, I_NMI_PIN, I_NMI_WD_TIMEOUT, I_MEM_ACCESS_ERR} = '0;
        {I_UNCORR_ERR, I_SINGLE_ERR, I_SW_RESET} = '0;
        t_reset();
        t_vec(RESET_BASE);
        t_base();
        t_vec(BASE_MAX);
        t_prio();
        // Second reset must drop the moved base and the written levels
        t_reset();
        t_vec(RESET_BASE);
        t_evt();
        results();
    end
endmodule // cev_vectoring_tb

// [logic/cev_pkg.sv]
// Constants and types for the core exception vectoring block
package cev_pkg;
    localparam int ADDR_W = 32;
    localparam int VEC_W = 8;
    localparam logic [31:0] RESET_BASE = 32'h0000_0000;
    localparam logic [31:0] BASE_MIN = 32'h0000_0200;
    localparam logic [31:0] BASE_MAX = 32'h3fff_fe00;
    localparam logic [31:0] BASE_ALIGN_MASK = 32'h0000_01ff;
    localparam int SLOT_SHIFT = 2;
    localparam logic [7:0] VEC_SP = 8'h00;
    localparam logic [7:0] VEC_RESET = 8'h01;
    localparam logic [7:0] VEC_NMI = 8'h02;
    localparam logic [7:0] VEC_HARD_FAULT = 8'h03;
    localparam logic [7:0] VEC_BUSFAULT = 8'h05;
    localparam logic [7:0] VEC_LAST_EXC = 8'h0f;
    localparam logic [7:0] VEC_FIRST_IRQ = 8'h10;
    localparam logic [7:0] VEC_LAST_IRQ = 8'h6b;
    localparam int NUM_PRIO = 108;
    localparam int PRIO_W = 3;
    localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h0;
    localparam logic signed [2:0] PRIO_NMI = -3'sd2;
    localparam int NMI_SRC = 4;
    localparam int MEM_SRC = 3;
    localparam int WD_REQ = 2;

    typedef enum logic [2:0] {
        ST_RESET = 3'b001,
        ST_SP = 3'b010,
        ST_RUN = 3'b100
    } cev_state_t;
endpackage

// [logic/cev_sync.sv]
// Three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
module cev_sync #(
    parameter int W = 1
) (
    input wire logic I_CLOCK, // System clock
    input wire logic I_NRST, // Async reset, active low
    input wire logic [W-1:0] i_d, // Asynchronous inputs
    output logic [W-1:0] o_q // Filtered, synchronous level
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } cev_sync_st_t;
    cev_sync_st_t r;
    cev_sync_st_t next_r;

    always_comb begin
        next_r = r;
        next_r.s1 = i_d;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        for (int b = 0; b < W; b++) begin
            if (r.s2[b] == r.s3[b]) begin
                next_r.q[b] = r.s3[b];
            end
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign o_q = r.q;
endmodule // cev_sync

// [logic/cev_vectoring.sv]
// Exception vectoring: table base, slot addressing, priorities, fault routing
//
// Summary of operation
// - Stack pointer fetched from slot zero after reset
// - Exceptions one to fifteen each own slot
// - Interrupts 16 to 107 from offset 0x40
// - NMI priority -2, slot 0x8, four sources
// - Bus fault slot 0x14 from memory errors
// - Programmable priorities reset to zero
// - Table base zero after reset
// - Only privileged writes, base 0x200..0x3FFFFE00
// - Watchdogs take software reset, two requests
// - NMI watchdog takes NMI event, own request
// - Uncorrectable memory errors become bus fault
// - Single-bit errors become maskable interrupts
`timescale 1ns/10ps
module cev_vectoring
    import cev_pkg::*;
(
    input wire logic I_CLOCK, // System clock, 100 MHz
    input wire logic I_NRST, // Async system reset, active low
    input wire logic I_VEC_REQ, // Core asks for a slot address, pulse
    input wire logic [VEC_W-1:0] I_VEC_NUM, // Vector number asked for
    input wire logic I_BASE_WE, // Table offset register write strobe
    input wire logic I_BASE_PRIV, // Write is from privileged code
    input wire logic [ADDR_W-1:0] I_BASE_WDATA, // New table base
    input wire logic I_PRIO_WE, // Priority write strobe
    input wire logic [VEC_W-1:0] I_PRIO_NUM, // Vector whose priority is written
    input wire logic [PRIO_W-1:0] I_PRIO_WDATA, // New priority level
    input wire logic I_CLK_FAIL, // Clock failure, async
    input wire logic I_EXPANDER_ERR, // Second-core expander error, async
    input wire logic I_NMI_PIN, // External NMI pin, async
    input wire logic I_NMI_WD_TIMEOUT, // Second-core NMI watchdog timeout, async
    input wire logic I_MEM_ACCESS_ERR, // Bus access error, precise
    input wire logic [MEM_SRC-1:0] I_UNCORR_ERR, // Local RAM, flash, shared RAM
    input wire logic [1:0] I_SINGLE_ERR, // Correctable errors: RAM, flash
    input wire logic I_SW_RESET, // Software reset from the irq controller
    output logic O_SP_FETCH, // Fetch stack pointer now, pulse
    output logic O_SLOT_VALID, // Slot address valid, pulse
    output logic [ADDR_W-1:0] O_SLOT_ADDR, // Address of the vector slot
    output logic [PRIO_W-1:0] O_SLOT_PRIO, // Priority of the vector asked for
    output logic O_SLOT_FIXED, // Vector has a fixed priority
    output logic [ADDR_W-1:0] O_BASE, // Current table base
    output logic O_BASE_REJECT, // Last base write refused, pulse
    output logic O_NMI, // Non-maskable exception request, level
    output logic O_BUS_FAULT, // Bus fault request, level
    output logic O_BUS_FAULT_IMPRECISE, // Bus fault is imprecise
    output logic [1:0] O_SINGLE_IRQ, // Maskable single-error interrupts
    output logic [WD_REQ-1:0] O_WD_RESET_REQ, // Watchdog reset requests
    output logic O_NMI_WD_RESET_REQ, // NMI watchdog reset request
    output logic O_NONMASKABLE_EVENT // NMI event towards the NMI watchdog
);
    typedef struct packed {
        cev_state_t state;
        logic sp_fetch;
        logic slot_valid;
        logic [ADDR_W-1:0] slot_addr;
        logic [PRIO_W-1:0] slot_prio;
        logic slot_fixed;
        logic [ADDR_W-1:0] base;
        logic base_reject;
        logic nmi;
        logic bus_fault;
        logic bus_fault_imp;
        logic [1:0] single_irq;
        logic [WD_REQ-1:0] wd_req;
        logic nmi_wd_req;
        logic nmi_event;
        logic [NUM_PRIO-1:0][PRIO_W-1:0] prio;
    } cev_st_t;

    cev_st_t r;
    cev_st_t next_r;
    logic [NMI_SRC-1:0] nmi_sync;
    logic [NMI_SRC-1:0] nmi_raw;

    // Decoded qualifiers for writes, lookups and events
    logic base_priv_ok;
    logic base_in_range;
    logic base_aligned;
    logic base_accept;
    logic prio_writable;
    logic vec_fixed;
    logic vec_in_table;
    logic [ADDR_W-1:0] vec_offset;
    logic nmi_any;
    logic uncorr_any;
    logic fault_any;
    logic fault_imprecise;
    logic [WD_REQ-1:0] wd_copies;

    assign nmi_raw = {I_NMI_WD_TIMEOUT, I_NMI_PIN, I_EXPANDER_ERR, I_CLK_FAIL};

    // Base write qualification; a refused write leaves the old base in place
    assign base_priv_ok = I_BASE_PRIV;
    assign base_in_range = (I_BASE_WDATA >= BASE_MIN) && (I_BASE_WDATA <= BASE_MAX);
    assign base_aligned = (I_BASE_WDATA & BASE_ALIGN_MASK) == '0;
    assign base_accept = base_priv_ok && base_in_range && base_aligned;

    // Vectors up to hard fault have fixed levels, so writes to them are dropped
    assign vec_fixed = I_VEC_NUM <= VEC_HARD_FAULT;
    assign vec_in_table = I_VEC_NUM <= VEC_LAST_IRQ;
    assign prio_writable = (I_PRIO_NUM > VEC_HARD_FAULT)
        && (I_PRIO_NUM <= VEC_LAST_IRQ);

    // One word per slot; an 8-bit number shifted by two cannot overflow
    assign vec_offset = ADDR_W'(I_VEC_NUM) << SLOT_SHIFT;

    // Any of the four sources raises the same NMI
    assign nmi_any = |nmi_sync;
    assign uncorr_any = |I_UNCORR_ERR;

    // Precise wins when an access error and a data error coincide
    assign fault_any = I_MEM_ACCESS_ERR || uncorr_any;
    assign fault_imprecise = uncorr_any && !I_MEM_ACCESS_ERR;

    // Both watchdog request lines mirror the software reset level
    assign wd_copies = {WD_REQ{I_SW_RESET}};

    // NMI sources are asynchronous to this clock
    // A source pulse shorter than two clocks may be missed
    cev_sync #(
        .W(NMI_SRC)
    ) u_nmi_sync (
        .I_CLOCK(I_CLOCK),
        .I_NRST(I_NRST),
        .i_d(nmi_raw),
        .o_q(nmi_sync)
    );

    always_comb begin
        next_r = r;
        next_r.sp_fetch = 1'b0;
        next_r.slot_valid = 1'b0;
        next_r.base_reject = 1'b0;

        unique case (r.state)
            ST_RESET: begin
                // One quiet cycle after reset before slot zero is fetched
                next_r.state = ST_SP;
            end
            ST_SP: begin
                // Slot zero holds the initial stack pointer
                next_r.sp_fetch = 1'b1;
                next_r.slot_addr = r.base + ADDR_W'(VEC_SP);
                next_r.state = ST_RUN;
            end
            ST_RUN: begin
                if (I_VEC_REQ) begin
                    next_r.slot_valid = 1'b1;
                    // One word per vector, exceptions and interrupts alike
                    next_r.slot_addr = r.base + vec_offset;
                    next_r.slot_fixed = vec_fixed;
                    if (I_VEC_NUM == VEC_NMI) begin
                        next_r.slot_prio = PRIO_W'(PRIO_NMI);
                    end else if (vec_in_table) begin
                        next_r.slot_prio = r.prio[I_VEC_NUM];
                    end else begin
                        next_r.slot_prio = PRIO_RESET;
                    end
                end
            end
            default: begin
                // A corrupt state code restarts the fetch sequence
                next_r.state = ST_RESET;
            end
        endcase

        // Refuse unprivileged, out-of-range or unaligned bases; base kept
        if (I_BASE_WE) begin
            if (base_accept) begin
                next_r.base = I_BASE_WDATA;
            end else begin
                next_r.base_reject = 1'b1;
            end
        end

        // Fixed-priority vectors ignore priority writes
        if (I_PRIO_WE && prio_writable) begin
            next_r.prio[I_PRIO_NUM] = I_PRIO_WDATA;
        end

        next_r.nmi = nmi_any;
        // The watchdog request trails the event by one cycle
        next_r.nmi_event = nmi_any;
        next_r.nmi_wd_req = r.nmi_event;
        next_r.bus_fault = fault_any;
        next_r.bus_fault_imp = fault_imprecise;
        // Correctable errors stay maskable interrupts, never faults
        next_r.single_irq = I_SINGLE_ERR;
        next_r.wd_req = wd_copies;
    end

    // Base and priority table return to their reset values with the rest
    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            r <= '0;
            r.state <= ST_RESET;
            r.base <= RESET_BASE;
            r.prio <= '0;
        end else begin
            r <= next_r;
        end
    end

    // Every output is a register bit of the state record
    assign O_SP_FETCH = r.sp_fetch;
    assign O_SLOT_VALID = r.slot_valid;
    assign O_SLOT_ADDR = r.slot_addr;
    assign O_SLOT_PRIO = r.slot_prio;
    assign O_SLOT_FIXED = r.slot_fixed;
    assign O_BASE = r.base;
    assign O_BASE_REJECT = r.base_reject;
    assign O_NMI = r.nmi;
    assign O_BUS_FAULT = r.bus_fault;
    assign O_BUS_FAULT_IMPRECISE = r.bus_fault_imp;
    assign O_SINGLE_IRQ = r.single_irq;
    assign O_WD_RESET_REQ = r.wd_req;
    assign O_NMI_WD_RESET_REQ = r.nmi_wd_req;
    assign O_NONMASKABLE_EVENT = r.nmi_event;
endmodule // cev_vectoring
